// [sim/host_model.sv]
// Host side of the pins: pull-ups on the open-drain lines the host reads
module host_model (
  input  wire pin_select_pkg::od_pin_t sec_pin, // Secondary pin drive
  input  wire pin_select_pkg::od_pin_t tmr_pin, // Timer pin drive
  input  wire pin_select_pkg::od_pin_t rst_pin, // Reset pin drive
  output logic                         sec_lvl, // Secondary line level
  output logic                         tmr_lvl, // Timer line level
  output logic                         rst_lvl  // Reset line level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released line floats up to the pull-up, never to the last driven value
  assign sec_lvl = sec_pin.oe ? sec_pin.out : 1'b1;
  assign tmr_lvl = tmr_pin.oe ? tmr_pin.out : 1'b1;
  assign rst_lvl = rst_pin.oe ? rst_pin.out : 1'b1;
endmodule : host_model

// [sim/rtc_output_pin_select_sva.sv]
// Checker: assertions on the pin routing of the output pin select block
module rtc_output_pin_select_sva #(
  parameter bit TWO_WIRE_HOST = 1'b1 // Two-wire host variant
) (
  input wire logic                    clk,                      // Core clock
  input wire logic                    reset,                    // Sync reset
  input wire logic                    reg_write,                // Write strobe
  input wire logic [7:0]              reg_addr,                 // Offset
  input wire logic [7:0]              reg_wdata,                // Write data
  input wire pin_select_pkg::source_t sources,                  // Sources
  input wire logic                    external_reset_input,     // Reset pin in
  input wire pin_select_pkg::od_pin_t secondary_irq_switch_pin, // Secondary pin
  input wire logic                    power_switch_mode,        // Switch mode
  input wire pin_select_pkg::od_pin_t timer_interrupt_pin_low,  // Timer pin
  input wire logic                    clock_output_pin,         // Clock pin
  input wire pin_select_pkg::od_pin_t reset_output_pin          // Reset pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]              oc, sq, ocd, sqd;
  logic                    live, so;
  pin_select_pkg::source_t sd;
  assign so = secondary_irq_switch_pin.oe;
  // Shadow registers plus one-cycle copies, since pins lag their causes by a cycle
  always_ff @(posedge clk) begin
    live <= !reset;
    ocd <= oc;
    sqd <= sq;
    sd <= sources;
    if (reset) begin
      oc <= 8'h00;
      sq <= 8'h00;
    end else if (reg_write && reg_addr == 8'h11) oc <= reg_wdata;
    else if (reg_write && reg_addr == 8'h13) sq <= reg_wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_sec_static: assert property (
    live && !ocd[6] && ocd[2:0] == 3'h0 |-> so == !ocd[4]) else $error("Static level wrong");
  chk_sec_square: assert property (
    live && !ocd[6] && ocd[2:0] == 3'h1 |-> so == (sqd[7] && !sd.square_wave))
    else $error("Secondary square wave wrong");
  chk_irq_alarm: assert property (
    live && !ocd[6] && ocd[2:1] == 2'h1 |-> so == (ocd[0] ? sd.alarm_interrupt : sd.combined_irq))
    else $error("Inverted interrupt wrong");
  chk_timer_sense: assert property (
    live && !ocd[6] && ocd[2:1] == 2'h2 |-> so == (sd.timer_interrupt == ocd[0]))
    else $error("Timer sense wrong");
  chk_power_switch: assert property (
    live && ocd[6] |-> power_switch_mode && so == sd.power_switch_close)
    else $error("Power switch wrong");
  chk_drain_only: assert property (
    !(secondary_irq_switch_pin.out || timer_interrupt_pin_low.out || reset_output_pin.out))
    else $error("Open drain drives high");
  chk_timer_pin: assert property (
    live |-> timer_interrupt_pin_low.oe == (TWO_WIRE_HOST && sd.timer_interrupt))
    else $error("Timer pin wrong");
  chk_clock_pin: assert property (
    live |-> clock_output_pin == (ocd[3] ? sqd[7] && sd.square_wave : ocd[5]))
    else $error("Clock pin wrong");
  chk_reset_acal: assert property (
    live && sd.autocal_fail_interrupt |-> reset_output_pin.oe == !ocd[7])
    else $error("Autocal reset wrong");
  chk_reset_pass: assert property (
    (!external_reset_input && sq[6] && !oc[7])[*6] |-> reset_output_pin.oe)
    else $error("Reset pass-through wrong");
endmodule : rtc_output_pin_select_sva
bind rtc_output_pin_select rtc_output_pin_select_sva #(.TWO_WIRE_HOST(TWO_WIRE_HOST)) chk (
  .clk(clk), .reset(reset), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .sources(sources), .external_reset_input(external_reset_input),
  .secondary_irq_switch_pin(secondary_irq_switch_pin), .power_switch_mode(power_switch_mode),
  .timer_interrupt_pin_low(timer_interrupt_pin_low), .clock_output_pin(clock_output_pin),
  .reset_output_pin(reset_output_pin));

// [sim/rtc_output_pin_select_tb.sv]
// Testbench: random writes, sources and reset pin against a pin model
module rtc_output_pin_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk = 1'b0, reset = 1'b1, reg_write = 1'b0, ext = 1'b1;
  logic [7:0]              reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, moc, msq;
  logic [4:0]              freq;
  logic                    psw, clk_pin, sec_lvl, tmr_lvl, rst_lvl;
  pin_select_pkg::source_t src = 6'h00;
  pin_select_pkg::od_pin_t sec, tmr, rst, tmr4;
  int                      error_cnt = 0, n_checks = 0, hi_cnt = 0, lo_cnt = 0;
  always #2.5 clk = ~clk;
  rtc_output_pin_select uut (.clk(clk), .reset(reset), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sources(src),
    .external_reset_input(ext), .square_wave_freq(freq), .secondary_irq_switch_pin(sec),
    .power_switch_mode(psw), .timer_interrupt_pin_low(tmr), .clock_output_pin(clk_pin),
    .reset_output_pin(rst));
  // Four-wire variant: its timer pin must never pull
  rtc_output_pin_select #(.TWO_WIRE_HOST(1'b0)) uut_four_wire (.clk(clk), .reset(reset),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(),
    .sources(src), .external_reset_input(ext), .square_wave_freq(),
    .secondary_irq_switch_pin(), .power_switch_mode(), .timer_interrupt_pin_low(tmr4),
    .clock_output_pin(), .reset_output_pin());
  host_model host (.sec_pin(sec), .tmr_pin(tmr), .rst_pin(rst), .sec_lvl(sec_lvl),
    .tmr_lvl(tmr_lvl), .rst_lvl(rst_lvl));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Expected secondary line level; bit 0 power close .. bit 5 combined irq
  function automatic logic sec_exp(input logic [7:0] c, input logic [7:0] s, input logic [5:0] v);
    if (c[6]) return !v[0];
    case (c[2:0])
      3'h0: return c[4];
      3'h1: return s[7] ? v[1] : 1'b1;
      3'h2: return !v[5];
      3'h3: return !v[4];
      3'h4: return v[3];
      3'h5: return !v[3];
      default: return 1'b1;
    endcase
  endfunction : sec_exp
  // One clock of stimulus; the model uses the registers as they stood before the edge
  task automatic step(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [5:0] v);
    logic [7:0] c;
    logic [7:0] s;
    logic       asr;
    c = moc;
    s = msq;
    reg_write <= w;
    reg_addr <= a;
    reg_wdata <= d;
    src <= v;
    @(posedge clk);
    #1;
    hi_cnt = ext ? hi_cnt + 1 : 0;
    lo_cnt = ext ? 0 : lo_cnt + 1;
    asr = v[2] || (s[6] && lo_cnt > 6);
    check(8'(sec_lvl), 8'(sec_exp(c, s, v)));
    check(8'(psw), 8'(c[6]));
    check(8'(clk_pin), 8'(c[3] ? s[7] && v[1] : c[5]));
    check(8'(tmr_lvl), 8'(!v[3]));
    check(8'(tmr4.oe), 8'h00);
    if (hi_cnt > 6 || lo_cnt > 6) check(8'(rst_lvl), 8'(c[7] ? asr : !asr));
    check(reg_rdata, a == 8'h11 ? c : a == 8'h13 ? s : 8'h00);
    if (w && a == 8'h11) moc = d;
    if (w && a == 8'h13) msq = d;
    check(8'(freq), 8'(msq[4:0]));
  endtask : step
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // Main sequence: reset, random traffic, a second reset halfway
  initial begin
    void'($urandom(91));
    for (int i = 0; i < 2000; i++) begin
      if (i % 1000 == 0) begin
        reset <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        reset <= 1'b0;
        moc = 8'h00;
        msq = 8'h00;
        hi_cnt = 0;
        lo_cnt = 0;
      end
      if ($urandom % 32 == 0) ext <= !ext;
      #0;
      step($urandom % 4 == 0, $urandom % 3 == 0 ? 8'h11 : ($urandom % 2 ? 8'h13 : 8'($urandom)),
        8'($urandom), 6'($urandom));
    end
    close_out();
  end
  // Watchdog against a hang
  initial begin
    #20000;
    error_cnt++;
    close_out();
  end
endmodule : rtc_output_pin_select_tb

// [src/pin_select_pkg.sv]
// Package: register map, field positions and types of the output pin selection block
// Function
// - Secondary pin is open drain, source picked by select field at 0x11.
// - Power switch enable turns the secondary pin into a power switch.
// - One secondary selection drives the software static level bit.
// - Secondary pin can carry the square wave only while its enable is set.
// - One secondary selection drives the inverse of the combined interrupt.
// - One secondary selection drives the inverse of the alarm interrupt.
// - Secondary pin offers the timer interrupt true or inverted.
// - Timer pin is open drain, always timer interrupt active low.
// - Timer pin exists only in the two-wire host variant.
// - Clock pin is push-pull, choosing static bit or square wave.
// - Clock pin static selection follows its software static level bit.
// - Clock pin carries the square wave only while its enable is set.
// - Reset output is open drain; polarity bit clears to 0, active low.
// - Secondary pin only pulls low or releases, never drives high.
// - Autocalibration failure can assert the reset output.
// - Low external reset input with pass enable asserts the reset output.
package pin_select_pkg;

  // Register offsets
  localparam logic [7:0] OUTPUT_CONTROL_ADDR     = 8'h11;
  localparam logic [7:0] SQUARE_WAVE_CONFIG_ADDR = 8'h13;

  // Output control fields
  localparam int SEC_SELECT_LSB        = 0;
  localparam int SEC_SELECT_WIDTH      = 3;
  localparam int CLK_SELECT_BIT        = 3;
  localparam int SEC_STATIC_BIT        = 4;
  localparam int CLK_STATIC_BIT        = 5;
  localparam int POWER_SWITCH_BIT      = 6;
  localparam int RESET_POLARITY_BIT    = 7;

  // Square wave config fields
  localparam int SQW_FREQ_LSB          = 0;
  localparam int SQW_FREQ_WIDTH        = 5;
  localparam int EXT_RESET_PASS_BIT    = 6;
  localparam int SQW_ENABLE_BIT        = 7;

  // Reset values
  localparam logic [7:0] OUTPUT_CONTROL_RESET     = 8'h00;
  localparam logic [7:0] SQUARE_WAVE_CONFIG_RESET = 8'h00;

  // Secondary output select codes
  typedef enum logic [2:0] {
    SEC_STATIC     = 3'b000,
    SEC_SQUARE     = 3'b001,
    SEC_IRQ_N      = 3'b010,
    SEC_ALARM_N    = 3'b011,
    SEC_TIMER      = 3'b100,
    SEC_TIMER_N    = 3'b101,
    SEC_RELEASE_A  = 3'b110,
    SEC_RELEASE_B  = 3'b111
  } sec_select_t;

  // Internal event sources, all on clk
  typedef struct packed {
    logic combined_irq;
    logic alarm_interrupt;
    logic timer_interrupt;
    logic autocal_fail_interrupt;
    logic square_wave;
    logic power_switch_close;
  } source_t;

  // Open-drain pin drive: out is always low, oe pulls
  typedef struct packed {
    logic out;
    logic oe;
  } od_pin_t;

endpackage : pin_select_pkg

// [src/rtc_output_pin_select.sv]
// Module: routes interrupt, square wave, static and reset signals onto the output pins
module rtc_output_pin_select #(
  parameter bit TWO_WIRE_HOST = 1'b1               // Variant with two-wire host link
) (
  input  wire logic                    clk,                         // 200 MHz core clock
  input  wire logic                    reset,                       // Sync reset, active high
  input  wire logic                    reg_write,                   // Register write strobe
  input  wire logic [7:0]              reg_addr,                    // Register offset
  input  wire logic [7:0]              reg_wdata,                   // Write data
  output      logic [7:0]              reg_rdata,                   // Read data, registered
  input  wire pin_select_pkg::source_t sources,                     // Internal signal sources
  input  wire logic                    external_reset_input,        // Reset pin in, active low
  output      logic [4:0]              square_wave_freq,            // Rate to the generator
  output      pin_select_pkg::od_pin_t secondary_irq_switch_pin,    // Open-drain secondary pin
  output      logic                    power_switch_mode,           // Pin acts as power switch
  output      pin_select_pkg::od_pin_t timer_interrupt_pin_low,     // Open-drain timer pin
  output      logic                    clock_output_pin,            // Push-pull clock pin
  output      pin_select_pkg::od_pin_t reset_output_pin             // Open-drain reset pin
);

  // Offset match; shared by both write strobes and the read path
  function automatic logic addr_hit(
    input logic [7:0] addr,   // Offset on the bus
    input logic [7:0] target  // Offset of one register
  );
    return addr == target;
  endfunction : addr_hit

  // Secondary pin level ahead of the open-drain stage; spare codes release the pin
  function automatic logic secondary_level(
    input pin_select_pkg::sec_select_t sel,        // Decoded select field
    input logic                        static_lvl, // Software static level
    input logic                        sqw_en,     // Square wave enable
    input pin_select_pkg::source_t     src         // Internal sources
  );
    logic level;
    case (sel)
      pin_select_pkg::SEC_STATIC: begin
        level = static_lvl;
      end
      pin_select_pkg::SEC_SQUARE: begin
        // A disabled generator leaves the line released rather than stuck low
        level = sqw_en ? src.square_wave : 1'h1;
      end
      pin_select_pkg::SEC_IRQ_N: begin
        level = ~src.combined_irq;
      end
      pin_select_pkg::SEC_ALARM_N: begin
        level = ~src.alarm_interrupt;
      end
      pin_select_pkg::SEC_TIMER: begin
        level = src.timer_interrupt;
      end
      pin_select_pkg::SEC_TIMER_N: begin
        level = ~src.timer_interrupt;
      end
      default: begin
        level = 1'h1;
      end
    endcase
    return level;
  endfunction : secondary_level

  // Clock pin level: square wave when selected and enabled, low when selected but disabled, else the static bit
  function automatic logic clock_level(
    input logic use_square, // Source select, 1 picks the square wave
    input logic sqw_en,     // Square wave enable
    input logic wave,       // Square wave from the generator
    input logic static_lvl  // Software static level
  );
    if (use_square) begin
      // A stopped generator parks the push-pull pin low, never at a stale level
      return sqw_en & wave;
    end
    return static_lvl;
  endfunction : clock_level

  // Reset pin pull: active low pulls while asserted, active high pulls while idle
  function automatic logic reset_pull_for(
    input logic polarity, // 0 active low, 1 active high
    input logic asserted  // Reset requested
  );
    return polarity ? ~asserted : asserted;
  endfunction : reset_pull_for

  // Synchroniser settle: take a new level only once two stages agree
  function automatic logic settled(
    input logic held,  // Level accepted so far
    input logic newer, // Second stage
    input logic older  // Third stage
  );
    return (newer == older) ? older : held;
  endfunction : settled

  // Control register: whole-byte writes; reset clears it, so the reset pin starts active low
  logic [7:0] output_control;
  logic [7:0] next_output_control;

  // Write decode for the control register
  always_comb begin
    next_output_control = output_control;
    if (reg_write && addr_hit(reg_addr, pin_select_pkg::OUTPUT_CONTROL_ADDR)) begin
      next_output_control = reg_wdata;
    end
  end

  // Control register flops
  always_ff @(posedge clk) begin
    if (reset) begin
      output_control <= pin_select_pkg::OUTPUT_CONTROL_RESET;
    end else begin
      output_control <= next_output_control;
    end
  end

  // Square wave config register: rate, enable and reset pass-through enable
  logic [7:0] square_wave_config;
  logic [7:0] next_square_wave_config;

  // Write decode for the config register
  always_comb begin
    next_square_wave_config = square_wave_config;
    if (reg_write && addr_hit(reg_addr, pin_select_pkg::SQUARE_WAVE_CONFIG_ADDR)) begin
      next_square_wave_config = reg_wdata;
    end
  end

  // Config register flops
  always_ff @(posedge clk) begin
    if (reset) begin
      square_wave_config <= pin_select_pkg::SQUARE_WAVE_CONFIG_RESET;
    end else begin
      square_wave_config <= next_square_wave_config;
    end
  end

  // Read data: registered, so it follows the offset one cycle late
  logic [7:0] next_reg_rdata;

  // Read mux; unmapped offsets read zero
  always_comb begin
    if (addr_hit(reg_addr, pin_select_pkg::OUTPUT_CONTROL_ADDR)) begin
      next_reg_rdata = output_control;
    end else if (addr_hit(reg_addr, pin_select_pkg::SQUARE_WAVE_CONFIG_ADDR)) begin
      next_reg_rdata = square_wave_config;
    end else begin
      next_reg_rdata = 8'h00;
    end
  end

  // Read data flops
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // Field extraction; every pin reads the registers through these names
  pin_select_pkg::sec_select_t secondary_output_select;
  logic                        clock_use_square;
  logic                        secondary_static_level;
  logic                        clock_static_level;
  logic                        power_switch_enable;
  logic                        reset_polarity;
  logic                        square_wave_enable;
  logic                        external_reset_pass_enable;

  assign secondary_output_select    = pin_select_pkg::sec_select_t'(output_control[
                                        pin_select_pkg::SEC_SELECT_LSB +:
                                        pin_select_pkg::SEC_SELECT_WIDTH]);
  assign clock_use_square           = output_control[pin_select_pkg::CLK_SELECT_BIT];
  assign secondary_static_level     = output_control[pin_select_pkg::SEC_STATIC_BIT];
  assign clock_static_level         = output_control[pin_select_pkg::CLK_STATIC_BIT];
  assign power_switch_enable        = output_control[pin_select_pkg::POWER_SWITCH_BIT];
  assign reset_polarity             = output_control[pin_select_pkg::RESET_POLARITY_BIT];
  assign square_wave_enable         = square_wave_config[pin_select_pkg::SQW_ENABLE_BIT];
  assign external_reset_pass_enable = square_wave_config[pin_select_pkg::EXT_RESET_PASS_BIT];

  // External reset pin: three flops; a change counts once stages two and three agree
  logic [2:0] ext_sync;
  logic [2:0] next_ext_sync;
  logic       ext_level;
  logic       next_ext_level;

  // Shift the pin in and accept a level only when it has stood two stages
  always_comb begin
    next_ext_sync  = {ext_sync[1:0], external_reset_input};
    next_ext_level = settled(ext_level, ext_sync[1], ext_sync[2]);
  end

  // Reset parks the chain at the idle high level so release shows no false low
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_sync  <= 3'h7;
      ext_level <= 1'h1;
    end else begin
      ext_sync  <= next_ext_sync;
      ext_level <= next_ext_level;
    end
  end

  // Secondary pin: registered so a select change cannot glitch the line
  logic sec_level;
  logic sec_pull;
  logic next_sec_pull;

  // Source mux, then the open-drain or power switch stage
  always_comb begin
    sec_level = secondary_level(secondary_output_select, secondary_static_level,
                                square_wave_enable, sources);
    // Power switch mode closes the switch to ground on request instead of showing a level
    if (power_switch_enable) begin
      next_sec_pull = sources.power_switch_close;
    end else begin
      next_sec_pull = ~sec_level;
    end
  end

  // Secondary pin flop
  always_ff @(posedge clk) begin
    if (reset) begin
      sec_pull <= 1'h0;
    end else begin
      sec_pull <= next_sec_pull;
    end
  end

  // Power switch flag tells the pad to use the low-resistance switch, not the driver
  logic next_power_switch_mode;

  // Mode follows its control bit
  always_comb begin
    next_power_switch_mode = power_switch_enable;
  end

  // Power switch flag flop, in step with the secondary pin
  always_ff @(posedge clk) begin
    if (reset) begin
      power_switch_mode <= 1'h0;
    end else begin
      power_switch_mode <= next_power_switch_mode;
    end
  end

  // Timer pin: timer interrupt active low, no options; the four-wire variant has none
  logic timer_pull;
  logic next_timer_pull;

  // Pull while the timer interrupt is pending
  always_comb begin
    next_timer_pull = TWO_WIRE_HOST && sources.timer_interrupt;
  end

  // Timer pin flop
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_pull <= 1'h0;
    end else begin
      timer_pull <= next_timer_pull;
    end
  end

  // Clock pin: push-pull, registered like the others so all pins move on one edge
  logic next_clock_out;

  // Two-way source select
  always_comb begin
    next_clock_out = clock_level(clock_use_square, square_wave_enable,
                                 sources.square_wave, clock_static_level);
  end

  // Clock pin flop
  always_ff @(posedge clk) begin
    if (reset) begin
      clock_output_pin <= 1'h0;
    end else begin
      clock_output_pin <= next_clock_out;
    end
  end

  // Reset pin: calibration failure or a passed-through external reset assert it
  logic reset_asserted;
  logic reset_pull;
  logic next_reset_pull;

  // Gather the reset causes, then apply the chosen polarity
  always_comb begin
    reset_asserted  = sources.autocal_fail_interrupt
                    | (external_reset_pass_enable & ~ext_level);
    next_reset_pull = reset_pull_for(reset_polarity, reset_asserted);
  end

  // Reset pin flop
  always_ff @(posedge clk) begin
    if (reset) begin
      reset_pull <= 1'h0;
    end else begin
      reset_pull <= next_reset_pull;
    end
  end

  // Open-drain pins only ever pull low; the far end's pull-up makes the high level
  assign secondary_irq_switch_pin = '{out: 1'h0, oe: sec_pull};
  assign timer_interrupt_pin_low  = '{out: 1'h0, oe: timer_pull};
  assign reset_output_pin         = '{out: 1'h0, oe: reset_pull};

  // Rate field goes straight to the generator outside this block
  assign square_wave_freq = square_wave_config[
                              pin_select_pkg::SQW_FREQ_LSB +: pin_select_pkg::SQW_FREQ_WIDTH];

endmodule : rtc_output_pin_select
